/* File: rtl/cjo_core.sv */
// Purpose: Execution core for jumps, calls, accumulator, bit and load operations
// Assumes: Program and data memory answer in the same cycle as the address
// Notes: One cycle per instruction byte, then one execute cycle, two for calls
`timescale 1ns/1ps
module cjo_core (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    output logic [cjo_pkg::PC_W-1:0] prog_addr_o,
    input wire logic [cjo_pkg::DW-1:0] prog_data_i,
    output logic [cjo_pkg::DW-1:0] dmem_addr_o,
    output logic [cjo_pkg::DW-1:0] dmem_wdata_o,
    output logic dmem_we_o,
    input wire logic [cjo_pkg::DW-1:0] dmem_rdata_i,
    output logic [cjo_pkg::DW-1:0] acc_o,
    output logic carry_o,
    output logic half_carry_o,
    output logic [cjo_pkg::DW-1:0] data_seg_o
);
    import cjo_pkg::*;

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    cjo_regs_s s; // Registered state
    cjo_regs_s next_s; // Next state
    logic [1:0] cls; // Opcode class
    logic [3:0] fn; // Accumulator function
    logic [1:0] md; // Operand mode
    logic [1:0] sub; // Misc subgroup
    logic [3:0] ext; // Extended code
    logic [2:0] bit_idx; // Selected bit
    logic [7:0] mask; // One-hot bit mask
    logic [7:0] d_addr; // Data address this cycle
    logic [7:0] rd; // Data read, pointers folded in
    logic [7:0] opnd; // General operand
    logic [7:0] opb; // Operand into adder
    logic alu_cin; // Adder carry in
    logic [8:0] sum; // Adder result with carry
    logic [4:0] hsum; // Low nibble sum with carry
    logic [6:0] rel_d; // Relative offset
    logic [14:0] rel_target; // Relative jump target
    logic [7:0] dec_val; // Decremented byte
    logic is_call; // Opcode is a call, in any state
    logic tbl_fetch; // Table read this cycle
    logic wr_en; // Data write this cycle
    logic [7:0] wr_data; // Data to write
    logic [1:0] ptr_step; // Pointer post step
    logic ptr_sel_x; // Step second pointer

    assign cls = s.op[7:6];
    assign fn = s.op[5:2];
    assign md = s.op[1:0];
    assign sub = s.op[5:4];
    assign ext = s.op[3:0];
    assign bit_idx = s.op[2:0];
    assign mask = 8'h01 << bit_idx;
    assign is_call = (cls == CLS_MISC) && (sub == SUB_EXT) &&
                     ((ext == EX_LCALL) || (ext == EX_SCALL));
    assign tbl_fetch = (s.st == ST_EXEC) && (cls == CLS_MISC) &&
                       (sub == SUB_EXT) && (ext == EX_TBL);

    // Instruction length from the opcode byte
    function automatic logic [1:0] cjo_len(input logic [7:0] o);
        logic [1:0] n;
        n = LEN1;
        case (o[7:6])
            CLS_ALU: n = (o[1:0] == MD_DIR || o[1:0] == MD_IMM) ? LEN2 : LEN1;
            CLS_BIT: n = o[3] ? LEN2 : LEN1; // Direct form carries an address
            CLS_MISC: begin
                if (o[5:4] == SUB_SEGJ) begin
                    n = LEN2;
                end else if (o[5:4] == SUB_EXT) begin
                    case (o[3:0])
                        EX_LJMP, EX_LCALL, EX_LDM, EX_LDR, EX_SCALL: n = LEN3;
                        EX_DECREMENT_SKIP_ZERO, EX_LDS: n = LEN2;
                        default: n = LEN1;
                    endcase
                end
            end
            default: n = LEN1;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    // Data address selection per instruction
    always_comb begin
        d_addr = s.ptr_b;
        if (s.st == ST_PUSH) begin
            d_addr = s.sp - 8'h01;
        end else if (cls == CLS_ALU) begin
            if (md == MD_DIR) begin
                d_addr = s.b1;
            end else if (md == MD_X) begin
                d_addr = s.ptr_x;
            end
        end else if (cls == CLS_BIT) begin
            d_addr = s.op[3] ? s.b1 : s.ptr_b;
        end else if (cls == CLS_MISC && sub == SUB_PTR) begin
            d_addr = s.op[3] ? s.ptr_x : s.ptr_b;
        end else if (cls == CLS_MISC && sub == SUB_EXT) begin
            if (ext == EX_DECREMENT_SKIP_ZERO || ext == EX_LDR) begin
                d_addr = {REG_PAGE, s.b1[3:0]};
            end else if (ext == EX_LDM) begin
                d_addr = s.b1;
            end else if (is_call) begin
                d_addr = s.sp;
            end
        end
    end

    // Read data with pointer registers folded in; they live here, not in memory
    assign rd = (d_addr == ADDR_X) ? s.ptr_x : (d_addr == ADDR_SP) ? s.sp :
                (d_addr == ADDR_B) ? s.ptr_b : dmem_rdata_i;

    // Operand, adder and offsets
    assign opnd = (md == MD_IMM) ? s.b1 : rd;
    assign opb = (fn == FN_SUBTRACT_WITH_BORROW) ? ~opnd : opnd;
    assign alu_cin = (fn == FN_ADD) ? 1'b0 : s.carry;
    assign sum = {1'b0, s.acc} + {1'b0, opb} + {8'h00, alu_cin};
    assign hsum = {1'b0, s.acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, alu_cin};
    assign rel_d = {1'b0, s.op[5:0]} - REL_BIAS;
    assign rel_target = s.pc + {{8{rel_d[6]}}, rel_d};
    assign dec_val = rd - 8'h01;

    // ------------------------------------------------------------------
    // Sequencer and execute
    // ------------------------------------------------------------------
    // Next state for fetch, skip and execute
    always_comb begin
        next_s = s;
        wr_en = 1'b0;
        wr_data = s.acc;
        ptr_step = 2'h0;
        ptr_sel_x = s.op[3];
        case (s.st)
            ST_OP: begin
                next_s.op = prog_data_i;
                next_s.pc = s.pc + PC_INC;
                if (cjo_len(prog_data_i) != LEN1) begin
                    next_s.st = ST_B1;
                end else if (s.skip) begin
                    next_s.skip = 1'b0;
                end else begin
                    next_s.st = ST_EXEC;
                end
            end
            ST_B1: begin
                next_s.b1 = prog_data_i;
                next_s.pc = s.pc + PC_INC;
                if (cjo_len(s.op) == LEN3) begin
                    next_s.st = ST_B2;
                end else if (s.skip) begin
                    next_s.st = ST_OP;
                    next_s.skip = 1'b0;
                end else begin
                    next_s.st = ST_EXEC;
                end
            end
            ST_B2: begin
                next_s.b2 = prog_data_i;
                next_s.pc = s.pc + PC_INC;
                next_s.st = s.skip ? ST_OP : ST_EXEC;
                next_s.skip = 1'b0;
            end
            ST_PUSH: begin
                wr_en = 1'b1; // Upper counter bits below the lower
                wr_data = s.b1;
                next_s.sp = s.sp - 8'h02;
                next_s.st = ST_OP;
            end
            default: begin
                next_s.st = ST_OP;
                case (cls)
                    CLS_REL: next_s.pc = rel_target;
                    CLS_ALU: begin
                        case (fn)
                            FN_ADD: next_s.acc = sum[7:0];
                            FN_ADC, FN_SUBTRACT_WITH_BORROW: begin
                                next_s.acc = sum[7:0];
                                next_s.carry = sum[8];
                                next_s.hcarry = hsum[4];
                            end
                            FN_AND: next_s.acc = s.acc & opnd;
                            FN_OR: next_s.acc = s.acc | opnd;
                            FN_XOR: next_s.acc = s.acc ^ opnd;
                            FN_SKIP_UNLESS_EQUAL: next_s.skip = (s.acc != opnd);
                            FN_SKIP_UNLESS_GREATER: next_s.skip = !(s.acc > opnd);
                            FN_LDA: next_s.acc = opnd;
                            FN_XCH: begin
                                if (md != MD_IMM) begin
                                    next_s.acc = rd;
                                    wr_en = 1'b1;
                                end
                            end
                            default: next_s.st = ST_OP; // Spare codes do nothing
                        endcase
                    end
                    CLS_BIT: begin
                        case (s.op[5:4])
                            BK_SET: begin
                                wr_en = 1'b1;
                                wr_data = rd | mask;
                            end
                            BK_CLR: begin
                                wr_en = 1'b1;
                                wr_data = rd & ~mask;
                            end
                            BK_TST: next_s.skip = ~rd[bit_idx];
                            default: next_s.st = ST_OP; // Spare code does nothing
                        endcase
                    end
                    default: begin
                        case (sub)
                            SUB_NIB: next_s.skip = (s.ptr_b[3:0] == ext);
                            SUB_PTR: begin
                                next_s.acc = rd;
                                wr_en = ~s.op[2];
                                ptr_step = s.op[1:0];
                            end
                            SUB_SEGJ: next_s.pc[11:0] = {ext, s.b1};
                            default: begin
                                case (ext)
                                    EX_LJMP: next_s.pc = {s.b1[6:0], s.b2};
                                    EX_LCALL: begin
                                        next_s.pc = {s.b1[6:0], s.b2};
                                        wr_en = 1'b1;
                                        wr_data = s.pc[7:0];
                                        next_s.b1 = {1'b0, s.pc[14:8]};
                                        next_s.st = ST_PUSH;
                                    end
                                    EX_SCALL: begin
                                        next_s.pc[11:0] = {s.b1[3:0], s.b2};
                                        wr_en = 1'b1;
                                        wr_data = s.pc[7:0];
                                        next_s.b1 = {1'b0, s.pc[14:8]};
                                        next_s.st = ST_PUSH;
                                    end
                                    EX_TBL: next_s.pc[7:0] = prog_data_i;
                                    EX_DECREMENT_SKIP_ZERO: begin
                                        wr_en = 1'b1;
                                        wr_data = dec_val;
                                        next_s.skip = (dec_val == 8'h00);
                                    end
                                    EX_LDM, EX_LDR: begin
                                        wr_en = 1'b1;
                                        wr_data = s.b2;
                                    end
                                    EX_LDS: next_s.seg = s.b1;
                                    default: next_s.st = ST_OP; // No operation
                                endcase
                            end
                        endcase
                    end
                endcase
            end
        endcase
        // Writes to pointer addresses land in the pointer registers, except a push write to the stack pointer address
        if (wr_en && d_addr == ADDR_X) begin
            next_s.ptr_x = wr_data;
        end else if (wr_en && d_addr == ADDR_SP && s.st != ST_PUSH) begin
            next_s.sp = wr_data;
        end else if (wr_en && d_addr == ADDR_B) begin
            next_s.ptr_b = wr_data;
        end
        // Post step of the pointer used by the exchange or load
        if (ptr_step == PS_INC || ptr_step == PS_DEC) begin
            if (ptr_sel_x) begin
                next_s.ptr_x = (ptr_step == PS_INC) ? s.ptr_x + 8'h01 : s.ptr_x - 8'h01;
            end else begin
                next_s.ptr_b = (ptr_step == PS_INC) ? s.ptr_b + 8'h01 : s.ptr_b - 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '{st: ST_OP, pc: RST_PC, acc: RST_ACC, ptr_b: RST_PTR,
                   ptr_x: RST_PTR, sp: RST_SP, seg: RST_SEG, carry: 1'b0,
                   hcarry: 1'b0, skip: 1'b0, op: 8'h00, b1: 8'h00, b2: 8'h00};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prog_addr_o = tbl_fetch ? {s.pc[14:8], s.acc} : s.pc;
    assign dmem_addr_o = d_addr;
    assign dmem_wdata_o = wr_data;
    assign dmem_we_o = wr_en && (d_addr != ADDR_X) && (d_addr != ADDR_SP) && (d_addr != ADDR_B);
    assign acc_o = s.acc;
    assign carry_o = s.carry;
    assign half_carry_o = s.hcarry;
    assign data_seg_o = s.seg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    rel_jump_a: assert property (
        (s.st == ST_EXEC && cls == CLS_REL) |=> s.pc == $past(rel_target))
        else $error("relative jump target wrong");
    seg_jump_a: assert property (
        (s.st == ST_EXEC && cls == CLS_MISC && sub == SUB_SEGJ) |=>
        s.pc[14:12] == $past(s.pc[14:12]) && s.pc[11:0] == {$past(ext), $past(s.b1)})
        else $error("segment jump changed upper bits or missed target");
    long_call_a: assert property (
        (s.st == ST_EXEC && is_call && ext == EX_LCALL) |=>
        s.st == ST_PUSH && s.pc == {$past(s.b1[6:0]), $past(s.b2)} ##1 s.st == ST_OP)
        else $error("long call target or push sequence wrong");
    table_jump_a: assert property (
        tbl_fetch |-> prog_addr_o[7:0] == s.acc ##1
        s.pc[7:0] == $past(prog_data_i) && s.pc[14:8] == $past(s.pc[14:8]))
        else $error("table jump address or target wrong");
    adc_flags_a: assert property (
        (s.st == ST_EXEC && cls == CLS_ALU && fn == FN_ADC) |=>
        {s.carry, s.acc} == {1'b0, $past(s.acc)} + {1'b0, $past(opnd)} +
        {8'h00, $past(s.carry)})
        else $error("add with carry result wrong");
    cmp_keep_a: assert property (
        (s.st == ST_EXEC && cls == CLS_ALU && fn == FN_SKIP_UNLESS_EQUAL) |=>
        $stable(s.acc) && s.skip == ($past(s.acc) != $past(opnd)))
        else $error("equal compare altered accumulator or skip");
    decrement_skip_zero_write_a: assert property (
        (s.st == ST_EXEC && cls == CLS_MISC && sub == SUB_EXT && ext == EX_DECREMENT_SKIP_ZERO) |->
        d_addr[7:4] == REG_PAGE && wr_data == rd - 8'h01 && wr_en)
        else $error("decrement write wrong");
    bit_set_a: assert property (
        (s.st == ST_EXEC && cls == CLS_BIT && s.op[5:4] == BK_SET) |->
        wr_en && wr_data[bit_idx] && (wr_data | mask) == (rd | mask))
        else $error("bit set wrong");
    skip_quiet_a: assert property (
        s.skip && s.st != ST_EXEC |-> !wr_en ##1 s.st != ST_EXEC && $stable(s.acc))
        else $error("skipped instruction had an effect");
    skip_cost_a: assert property (
        (s.st == ST_OP && s.skip && cjo_len(prog_data_i) == LEN2) |=>
        s.st == ST_B1 ##1 s.st == ST_OP && !s.skip)
        else $error("two byte skip took wrong cycles");
endmodule // cjo_core

/* File: rtl/cjo_pkg.sv */
// Purpose: Shared constants and types for the jump and operand execution core
// Assumes: Byte-wide program memory and data memory, both read without latency
// Notes: Opcode layout is local to this core; lengths are one to three bytes
package cjo_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int PC_W = 15; // Program counter width
    localparam int DW = 8; // Data byte width
    localparam logic [14:0] PC_INC = 15'h0001; // Fetch step
    // ------------------------------------------------------------------
    // Data addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_X = 8'hfc; // Second pointer
    localparam logic [7:0] ADDR_SP = 8'hfd; // Stack pointer
    localparam logic [7:0] ADDR_B = 8'hfe; // First pointer
    localparam logic [3:0] REG_PAGE = 4'hf; // Upper nibble of register page
    // ------------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------------
    localparam logic [1:0] CLS_REL = 2'h0; // Short relative jump
    localparam logic [1:0] CLS_ALU = 2'h1; // Accumulator operations
    localparam logic [1:0] CLS_BIT = 2'h2; // Bit operations
    localparam logic [1:0] CLS_MISC = 2'h3; // Everything else
    localparam logic [6:0] REL_BIAS = 7'h20; // Field minus bias, from next pc
    localparam logic [1:0] MD_DIR = 2'h0; // Direct data address
    localparam logic [1:0] MD_B = 2'h1; // Byte at first pointer
    localparam logic [1:0] MD_IMM = 2'h2; // Immediate byte
    localparam logic [1:0] MD_X = 2'h3; // Byte at second pointer
    localparam logic [3:0] FN_ADD = 4'h0;
    localparam logic [3:0] FN_ADC = 4'h1;
    localparam logic [3:0] FN_SUBTRACT_WITH_BORROW = 4'h2; // subtract_with_borrow
    localparam logic [3:0] FN_AND = 4'h3;
    localparam logic [3:0] FN_OR = 4'h4;
    localparam logic [3:0] FN_XOR = 4'h5;
    localparam logic [3:0] FN_SKIP_UNLESS_EQUAL = 4'h6; // skip_unless_equal
    localparam logic [3:0] FN_SKIP_UNLESS_GREATER = 4'h7; // skip_unless_greater
    localparam logic [3:0] FN_LDA = 4'h8; // load_move into accumulator
    localparam logic [3:0] FN_XCH = 4'h9; // Exchange accumulator with memory
    localparam logic [1:0] BK_SET = 2'h0; // bit_set_op
    localparam logic [1:0] BK_CLR = 2'h1; // bit_clear_op
    localparam logic [1:0] BK_TST = 2'h2; // skip_unless_bit
    localparam logic [1:0] SUB_NIB = 2'h0; // pointer_nibble_test
    localparam logic [1:0] SUB_PTR = 2'h1; // Pointer indirect load or exchange
    localparam logic [1:0] SUB_SEGJ = 2'h2; // segment_jump
    localparam logic [1:0] SUB_EXT = 2'h3; // Extended group
    localparam logic [3:0] EX_LJMP = 4'h0; // long_jump
    localparam logic [3:0] EX_LCALL = 4'h1; // long_call
    localparam logic [3:0] EX_TBL = 4'h2; // table_jump
    localparam logic [3:0] EX_DECREMENT_SKIP_ZERO = 4'h3; // decrement_skip_zero
    localparam logic [3:0] EX_LDM = 4'h4; // Load direct memory immediate
    localparam logic [3:0] EX_LDR = 4'h5; // Load register page immediate
    localparam logic [3:0] EX_SCALL = 4'h6; // segment_call
    localparam logic [3:0] EX_LDS = 4'h7; // Load data segment immediate
    localparam logic [1:0] PS_INC = 2'h1; // Post increment
    localparam logic [1:0] PS_DEC = 2'h2; // Post decrement
    localparam logic [1:0] LEN1 = 2'd1;
    localparam logic [1:0] LEN2 = 2'd2;
    localparam logic [1:0] LEN3 = 2'd3;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [14:0] RST_PC = 15'h0000;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [7:0] RST_PTR = 8'h00;
    localparam logic [7:0] RST_SP = 8'h2f;
    localparam logic [7:0] RST_SEG = 8'h00;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OP = 3'b000,
        ST_B1 = 3'b001,
        ST_B2 = 3'b011,
        ST_EXEC = 3'b010,
        ST_PUSH = 3'b110
    } cjo_state_e;
    typedef struct packed {
        cjo_state_e st; // Sequencer state
        logic [14:0] pc; // Upper seven and lower eight counter bits
        logic [7:0] acc; // Accumulator
        logic [7:0] ptr_b; // First pointer
        logic [7:0] ptr_x; // Second pointer
        logic [7:0] sp; // Stack pointer
        logic [7:0] seg; // Data segment
        logic carry; // Carry flag
        logic hcarry; // half_carry_flag
        logic skip; // Next instruction is to be skipped
        logic [7:0] op; // Opcode byte
        logic [7:0] b1; // Second instruction byte
        logic [7:0] b2; // Third instruction byte
    } cjo_regs_s;
endpackage

/* File: test/cjo_mem.sv */
// Purpose: Program and data memory model facing the execution core
// Assumes: Reads answer in the same cycle, writes land on the rising edge
// Notes: The bench loads rom and ram contents directly before each reset
`timescale 1ns/1ps
module cjo_mem (
    input wire logic clk_sys_i,
    input wire logic [14:0] prog_addr_i,
    output logic [7:0] prog_data_o,
    input wire logic [7:0] dmem_addr_i,
    input wire logic [7:0] dmem_wdata_i,
    input wire logic dmem_we_i,
    output logic [7:0] dmem_rdata_o
);
    logic [7:0] rom [0:32767]; // Program bytes
    logic [7:0] ram [0:255]; // Data bytes
    assign prog_data_o = rom[prog_addr_i];
    assign dmem_rdata_o = ram[dmem_addr_i];
    // Write port, one byte per strobe
    always @(posedge clk_sys_i) begin
        if (dmem_we_i) begin
            ram[dmem_addr_i] <= dmem_wdata_i;
        end
    end
endmodule // cjo_mem

/* File: test/cpu_jump_and_operand_ops_tb.sv */
// Purpose: Self-checking bench for the execution core
// Assumes: Programs end in a one-byte jump onto itself
// Notes: Each scenario reloads memory and resets the core
`timescale 1ns/1ps
module cpu_jump_and_operand_ops_tb;
    import cjo_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [14:0] pa;
    logic [7:0] pd, da, dw, dr, acc, seg;
    logic we, cy, hc;
    int n_fail = 0;
    int check_count = 0;
    cjo_core uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .prog_addr_o(pa),
        .prog_data_i(pd), .dmem_addr_o(da), .dmem_wdata_o(dw), .dmem_we_o(we),
        .dmem_rdata_i(dr), .acc_o(acc), .carry_o(cy), .half_carry_o(hc), .data_seg_o(seg));
    cjo_mem mem (.clk_sys_i(clk_sys_i), .prog_addr_i(pa), .prog_data_o(pd),
        .dmem_addr_i(da), .dmem_wdata_i(dw), .dmem_we_i(we), .dmem_rdata_o(dr));
    // Clock, 40 ns period
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Wipe memories, then place bytes from an address
    task automatic put(input logic [14:0] a, input logic [7:0] b [$]);
        foreach (b[i]) mem.rom[a + 15'(i)] = b[i];
    endtask
    task automatic wipe();
        for (int i = 0; i < 32768; i++) begin
            mem.rom[i] = 8'hff;
        end
        for (int i = 0; i < 256; i++) begin
            mem.ram[i] = 8'h00;
        end
    endtask
    // Reset for 4 cycles, then run 60 cycles
    task automatic run();
        @(negedge clk_sys_i) rst_n_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (60) @(negedge clk_sys_i);
    endtask
    // Load, add with carry, subtract with carry, then plain add keeps flags
    task automatic t_alu();
        wipe();
        put(15'h0000, '{8'h62, 8'hf0, 8'h46, 8'h20, 8'h48, 8'h10, 8'h46, 8'h01, 8'h42, 8'h05,
            8'h1f});
        mem.ram[8'h10] = 8'h02;
        run();
        chk("acc", 8'h15, acc);
        chk("carry", 8'h00, {7'h00, cy});
        chk("hcarry", 8'h01, {7'h00, hc});
        $display("alu test done");
    endtask
    // Compares, decrement skip, skipped store, bit set
    task automatic t_skip();
        wipe();
        put(15'h0000, '{8'h62, 8'h05, 8'h5a, 8'h06, 8'h62, 8'h99, 8'h5e, 8'h04, 8'hf4,
            8'h20, 8'h33, 8'hf3, 8'h01, 8'hf4, 8'h21, 8'h44, 8'h8b, 8'h22, 8'h1f});
        mem.ram[8'hf1] = 8'h01;
        mem.ram[8'h22] = 8'h81;
        run();
        chk("acc", 8'h05, acc);
        chk("ram20", 8'h33, mem.ram[8'h20]);
        chk("ramf1", 8'h00, mem.ram[8'hf1]);
        chk("ram21", 8'h00, mem.ram[8'h21]);
        chk("ram22", 8'h89, mem.ram[8'h22]);
        $display("skip test done");
    endtask
    // Long, segment, table and short relative jumps, segment load, both calls
    task automatic t_jump();
        wipe();
        put(15'h0000, '{8'hf0, 8'h12, 8'h34});
        put(15'h1234, '{8'he5, 8'h67});
        put(15'h1567, '{8'h62, 8'h80, 8'hf2});
        put(15'h1580, '{8'h40});
        put(15'h1540, '{8'h00});
        put(15'h1521, '{8'h62, 8'ha5, 8'hf7, 8'h3c, 8'hf1, 8'h20, 8'h00});
        put(15'h2000, '{8'hf6, 8'h03, 8'h10});
        put(15'h2310, '{8'h1f});
        run();
        chk("acc", 8'ha5, acc);
        chk("seg", 8'h3c, seg);
        chk("ret_lo", 8'h28, mem.ram[8'h2f]);
        chk("ret_hi", 8'h15, mem.ram[8'h2e]);
        chk("seg_ret_lo", 8'h03, mem.ram[8'h2d]);
        chk("seg_ret_hi", 8'h20, mem.ram[8'h2c]);
        $display("jump test done");
    endtask
    // Pointer loads, exchange with step, nibble and bit tests, bit clear, logic ops
    task automatic t_ptr();
        wipe();
        put(15'h0000, '{8'hf5, 8'h0e, 8'h30, 8'hf5, 8'h0c, 8'h40, 8'h62, 8'h77, 8'hd1, 8'hc1,
            8'h62, 8'h00, 8'hc5, 8'h4f, 8'ha8, 8'h50, 8'h62, 8'hff, 8'h99, 8'h50, 8'h55,
            8'h5e, 8'h20, 8'h62, 8'hee, 8'h1f});
        mem.ram[8'h30] = 8'h5a;
        mem.ram[8'h31] = 8'h03;
        mem.ram[8'h40] = 8'h0f;
        mem.ram[8'h50] = 8'h02;
        run();
        chk("acc", 8'h09, acc);
        chk("ram30", 8'h77, mem.ram[8'h30]);
        chk("ram50", 8'h00, mem.ram[8'h50]);
        $display("pointer test done");
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        t_alu();
        t_skip();
        t_jump();
        t_ptr();
        give_verdict();
    end
endmodule // cpu_jump_and_operand_ops_tb
